/* hdl/agu_pkg.sv */
`default_nettype none
package agu_pkg;
  localparam int ADDR_W     = 16;
  localparam int FREG_W     = 13;
  localparam int LIT5_W     = 5;
  localparam int LIT10_W    = 10;
  localparam int REGSEL_W   = 4;
  localparam int MODE_W     = 3;
  localparam int SEQ_W      = 2;
  localparam int CLASS_W    = 2;
  localparam int DEST_W     = 2;
  localparam int LITSEL_W   = 2;

  // Addressing modes
  localparam logic [2:0] MODE_FREG   = 3'h0;
  localparam logic [2:0] MODE_RDIR   = 3'h1;
  localparam logic [2:0] MODE_RIND   = 3'h2;
  localparam logic [2:0] MODE_POST   = 3'h3;
  localparam logic [2:0] MODE_PRE    = 3'h4;
  localparam logic [2:0] MODE_REGOFS = 3'h5;
  localparam logic [2:0] MODE_LITOFS = 3'h6;

  // Address sequencing
  localparam logic [1:0] SEQ_LINEAR = 2'h0;
  localparam logic [1:0] SEQ_MODULO = 2'h1;
  localparam logic [1:0] SEQ_BITREV = 2'h2;
  localparam logic [1:0] SEQ_ILLEGAL = 2'h3;

  // Instruction classes
  localparam logic [1:0] CLS_FREG = 2'h0;
  localparam logic [1:0] CLS_MCU  = 2'h1;
  localparam logic [1:0] CLS_XFER = 2'h2;
  localparam logic [1:0] CLS_MAC  = 2'h3;

  // Result destinations
  localparam logic [1:0] DST_FREG  = 2'h0;
  localparam logic [1:0] DST_ACC0  = 2'h1;
  localparam logic [1:0] DST_WORK  = 2'h2;
  localparam logic [1:0] DST_MEM   = 2'h3;

  // Literal operand kinds
  localparam logic [1:0] LIT_NONE = 2'h0;
  localparam logic [1:0] LIT_5    = 2'h1;
  localparam logic [1:0] LIT_10   = 2'h2;

  localparam logic [3:0] REG_ZERO = 4'h0;
  localparam logic [3:0] REG_W8  = 4'h8;
  localparam logic [3:0] REG_W9  = 4'h9;
  localparam logic [3:0] REG_W10 = 4'ha;
  localparam logic [3:0] REG_W11 = 4'hb;

  localparam logic [15:0] ADDR_ZERO = 16'h0000;
  localparam logic [2:0]  FREG_PAD  = 3'h0;
endpackage : agu_pkg
`default_nettype wire

/* hdl/agu_address_generation_unit.sv */
// How it works
// - X and Y generators compute addresses independently in the same cycle
// - Y generator only serves word reads of the MAC instruction class
// - Sequencing may be linear, modulo or bit-reversed
// - Bit-reversed sequencing only for X in data space, never for Y; linear and modulo anywhere
// - File-register 13-bit field selects a byte in the lowest 8192 bytes
// - File-register ops use working register zero; result to file or register zero
// - Product instruction writes a working register or register pair
// - Data transfer in file-register form reaches the whole data space
// - MCU op1 is register direct; op2 register, memory or 5-bit literal
// - MCU modes: direct, indirect, post, pre, 5 or 10-bit literals
// - File-register direct address comes only from the instruction
// - Register direct uses the register itself, no memory access
// - Register indirect uses the pointer value unchanged as address
// - Post-modify uses current pointer, then writes back pointer plus step
// - Pre-modify adds signed step first, uses and keeps the new value
// - Register offset address is pointer plus offset register
// - Literal offset address is pointer plus instruction literal
// - MAC reads: W8 and W9 go to X, W10 and W11 go to Y
`timescale 1ns/1ps
`default_nettype none
module agu_address_generation_unit (
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RESET,
  // X request
  input  wire logic        X_REQ,
  input  wire logic [1:0]  X_CLASS,
  input  wire logic [2:0]  X_MODE,
  input  wire logic [1:0]  X_SEQ,
  input  wire logic        X_PROG_SPACE,
  input  wire logic        X_PRODUCT,
  input  wire logic        X_DEST_W0,
  input  wire logic [12:0] X_FREG_ADDR,
  input  wire logic [15:0] X_FULL_ADDR,
  input  wire logic [3:0]  X_PTR_SEL,
  input  wire logic [15:0] X_PTR_VAL,
  input  wire logic [15:0] X_OFS_VAL,
  input  wire logic [15:0] X_STEP,
  input  wire logic [1:0]  X_LIT_KIND,
  input  wire logic [9:0]  X_LIT,
  // Y request
  input  wire logic        Y_REQ,
  input  wire logic [1:0]  Y_CLASS,
  input  wire logic [2:0]  Y_MODE,
  input  wire logic [1:0]  Y_SEQ,
  input  wire logic [3:0]  Y_PTR_SEL,
  input  wire logic [15:0] Y_PTR_VAL,
  input  wire logic [15:0] Y_OFS_VAL,
  input  wire logic [15:0] Y_STEP,
  // X result
  output logic             X_VALID,
  output logic [15:0]      X_EA,
  output logic             X_MEM_ACCESS,
  output logic             X_REG_OPERAND,
  output logic             X_WB_EN,
  output logic [3:0]       X_WB_SEL,
  output logic [15:0]      X_WB_VAL,
  output logic [1:0]       X_DEST,
  output logic             X_BITREV,
  output logic             X_LIT_VALID,
  output logic [15:0]      X_LIT_OUT,
  output logic             X_REJECT,
  // Y result
  output logic             Y_VALID,
  output logic [15:0]      Y_EA,
  output logic             Y_WB_EN,
  output logic [3:0]       Y_WB_SEL,
  output logic [15:0]      Y_WB_VAL,
  output logic             Y_REJECT
);

  // Address computation shared by both generators
  function automatic logic [15:0] calc_ea(input logic [2:0]  mode,
                                          input logic [15:0] ptr,
                                          input logic [15:0] ofs,
                                          input logic [15:0] step,
                                          input logic [15:0] fixed);
    logic [15:0] r;
    r = fixed;
    case (mode)
      agu_pkg::MODE_FREG:   r = fixed;
      agu_pkg::MODE_RIND:   r = ptr;
      agu_pkg::MODE_POST:   r = ptr;
      agu_pkg::MODE_PRE:    r = 16'(ptr + step);
      agu_pkg::MODE_REGOFS: r = 16'(ptr + ofs);
      agu_pkg::MODE_LITOFS: r = 16'(ptr + ofs);
      default:              r = agu_pkg::ADDR_ZERO;
    endcase
    return r;
  endfunction : calc_ea

  function automatic logic is_modify(input logic [2:0] mode);
    return (mode == agu_pkg::MODE_POST) || (mode == agu_pkg::MODE_PRE);
  endfunction : is_modify

  // X combinational
  logic [15:0] x_fixed;
  logic [15:0] x_lit_ext;
  logic [15:0] x_ofs;
  logic [15:0] x_ea_next;
  logic        x_ok;
  logic        x_mac_ptr;

  always_comb
  begin
    if (X_CLASS == agu_pkg::CLS_XFER)
      x_fixed = X_FULL_ADDR;
    else
      x_fixed = {agu_pkg::FREG_PAD, X_FREG_ADDR};
    if (X_LIT_KIND == agu_pkg::LIT_5)
      x_lit_ext = {11'h000, X_LIT[4:0]};
    else
      x_lit_ext = {6'h00, X_LIT};
    x_ofs = (X_MODE == agu_pkg::MODE_LITOFS) ? x_lit_ext : X_OFS_VAL;
    x_ea_next = calc_ea(X_MODE, X_PTR_VAL, x_ofs, X_STEP, x_fixed);
    x_mac_ptr = (X_PTR_SEL == agu_pkg::REG_W8) || (X_PTR_SEL == agu_pkg::REG_W9);
    x_ok = 1'b1;
    if ((X_SEQ == agu_pkg::SEQ_BITREV) && X_PROG_SPACE)
      x_ok = 1'b0;
    if (X_SEQ == agu_pkg::SEQ_ILLEGAL)
      x_ok = 1'b0;
    if ((X_CLASS == agu_pkg::CLS_MAC) && !x_mac_ptr)
      x_ok = 1'b0;
    if ((X_CLASS == agu_pkg::CLS_MCU) && (X_MODE > agu_pkg::MODE_PRE))
      x_ok = 1'b0;
    if ((X_CLASS == agu_pkg::CLS_FREG) && (X_MODE != agu_pkg::MODE_FREG))
      x_ok = 1'b0;
  end

  // Y combinational
  logic [15:0] y_ea_next;
  logic        y_ok;

  always_comb
  begin
    y_ea_next = calc_ea(Y_MODE, Y_PTR_VAL, Y_OFS_VAL, Y_STEP, agu_pkg::ADDR_ZERO);
    y_ok = (Y_CLASS == agu_pkg::CLS_MAC)
        && ((Y_PTR_SEL == agu_pkg::REG_W10) || (Y_PTR_SEL == agu_pkg::REG_W11))
        && (Y_SEQ != agu_pkg::SEQ_BITREV) && (Y_SEQ != agu_pkg::SEQ_ILLEGAL)
        && (Y_MODE != agu_pkg::MODE_FREG) && (Y_MODE != agu_pkg::MODE_RDIR)
        && (Y_MODE != agu_pkg::MODE_LITOFS);
  end

  // X generator registers
  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      X_VALID       <= 1'b0;
      X_EA          <= agu_pkg::ADDR_ZERO;
      X_MEM_ACCESS  <= 1'b0;
      X_REG_OPERAND <= 1'b0;
      X_WB_EN       <= 1'b0;
      X_WB_SEL      <= agu_pkg::REG_ZERO;
      X_WB_VAL      <= agu_pkg::ADDR_ZERO;
      X_BITREV      <= 1'b0;
      X_REJECT      <= 1'b0;
    end
    else
    begin
      X_VALID       <= X_REQ && x_ok;
      X_REJECT      <= X_REQ && !x_ok;
      X_EA          <= x_ea_next;
      X_MEM_ACCESS  <= X_REQ && x_ok && (X_MODE != agu_pkg::MODE_RDIR);
      X_REG_OPERAND <= X_REQ && x_ok && (X_MODE == agu_pkg::MODE_RDIR);
      X_WB_EN       <= X_REQ && x_ok && is_modify(X_MODE);
      X_WB_SEL      <= X_PTR_SEL;
      X_WB_VAL      <= 16'(X_PTR_VAL + X_STEP);
      X_BITREV      <= X_REQ && x_ok && (X_SEQ == agu_pkg::SEQ_BITREV);
    end
  end

  // X destination and literal
  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      X_DEST      <= agu_pkg::DST_FREG;
      X_LIT_VALID <= 1'b0;
      X_LIT_OUT   <= agu_pkg::ADDR_ZERO;
    end
    else
    begin
      if (X_CLASS == agu_pkg::CLS_FREG)
      begin
        if (X_PRODUCT)
          X_DEST <= agu_pkg::DST_WORK;
        else if (X_DEST_W0)
          X_DEST <= agu_pkg::DST_ACC0;
        else
          X_DEST <= agu_pkg::DST_FREG;
      end
      else
        X_DEST <= X_DEST_W0 ? agu_pkg::DST_WORK : agu_pkg::DST_MEM;
      X_LIT_VALID <= X_REQ && x_ok && (X_LIT_KIND != agu_pkg::LIT_NONE)
                     && (X_MODE == agu_pkg::MODE_RDIR);
      X_LIT_OUT   <= x_lit_ext;
    end
  end

  // Y generator registers
  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      Y_VALID  <= 1'b0;
      Y_EA     <= agu_pkg::ADDR_ZERO;
      Y_WB_EN  <= 1'b0;
      Y_WB_SEL <= agu_pkg::REG_W10;
      Y_WB_VAL <= agu_pkg::ADDR_ZERO;
      Y_REJECT <= 1'b0;
    end
    else
    begin
      Y_VALID  <= Y_REQ && y_ok;
      Y_REJECT <= Y_REQ && !y_ok;
      Y_EA     <= {y_ea_next[15:1], 1'b0};
      Y_WB_EN  <= Y_REQ && y_ok && is_modify(Y_MODE);
      Y_WB_SEL <= Y_PTR_SEL;
      Y_WB_VAL <= 16'(Y_PTR_VAL + Y_STEP);
    end
  end

  // Checks
  ind_ea_a: assert property (@(posedge CLK) disable iff (RESET)
    X_REQ && x_ok && X_MODE == agu_pkg::MODE_RIND |=> X_EA == $past(X_PTR_VAL) && !X_WB_EN)
    else $error("indirect address wrong");
  post_mod_a: assert property (@(posedge CLK) disable iff (RESET)
    X_REQ && x_ok && X_MODE == agu_pkg::MODE_POST
    |=> X_EA == $past(X_PTR_VAL) && X_WB_EN && X_WB_VAL == 16'($past(X_PTR_VAL) + $past(X_STEP)))
    else $error("post modify wrong");
  pre_mod_a: assert property (@(posedge CLK) disable iff (RESET)
    X_REQ && x_ok && X_MODE == agu_pkg::MODE_PRE
    |=> X_EA == 16'($past(X_PTR_VAL) + $past(X_STEP)) && X_WB_EN && X_WB_VAL == X_EA)
    else $error("pre modify wrong");
  reg_ofs_a: assert property (@(posedge CLK) disable iff (RESET)
    X_REQ && x_ok && X_MODE == agu_pkg::MODE_REGOFS
    |=> X_EA == 16'($past(X_PTR_VAL) + $past(X_OFS_VAL)) && !X_WB_EN)
    else $error("register offset wrong");
  lit_ofs_a: assert property (@(posedge CLK) disable iff (RESET)
    X_REQ && x_ok && X_MODE == agu_pkg::MODE_LITOFS && X_LIT_KIND != agu_pkg::LIT_5
    |=> X_EA == 16'($past(X_PTR_VAL) + {6'h00, $past(X_LIT)}) && !X_WB_EN)
    else $error("literal offset wrong");
  freg_near_a: assert property (@(posedge CLK) disable iff (RESET)
    X_REQ && x_ok && X_CLASS == agu_pkg::CLS_FREG |=> X_EA[15:13] == agu_pkg::FREG_PAD)
    else $error("file register not near");
  freg_direct_a: assert property (@(posedge CLK) disable iff (RESET)
    X_REQ && x_ok && X_CLASS == agu_pkg::CLS_FREG
    |=> X_EA == {agu_pkg::FREG_PAD, $past(X_FREG_ADDR)})
    else $error("file register address wrong");
  xfer_full_a: assert property (@(posedge CLK) disable iff (RESET)
    X_REQ && x_ok && X_CLASS == agu_pkg::CLS_XFER && X_MODE == agu_pkg::MODE_FREG
    |=> X_EA == $past(X_FULL_ADDR))
    else $error("data transfer address wrong");
  freg_dest_a: assert property (@(posedge CLK) disable iff (RESET)
    X_CLASS == agu_pkg::CLS_FREG && !X_PRODUCT
    |=> X_DEST == ($past(X_DEST_W0) ? agu_pkg::DST_ACC0 : agu_pkg::DST_FREG))
    else $error("file register destination wrong");
  product_dest_a: assert property (@(posedge CLK) disable iff (RESET)
    X_CLASS == agu_pkg::CLS_FREG && X_PRODUCT |=> X_DEST == agu_pkg::DST_WORK)
    else $error("product destination wrong");
  lit5_a: assert property (@(posedge CLK) disable iff (RESET)
    X_REQ && x_ok && X_MODE == agu_pkg::MODE_RDIR && X_LIT_KIND == agu_pkg::LIT_5
    |=> X_LIT_VALID && X_LIT_OUT == {11'h000, $past(X_LIT[4:0])})
    else $error("short literal wrong");
  mcu_mode_a: assert property (@(posedge CLK) disable iff (RESET)
    X_REQ && X_CLASS == agu_pkg::CLS_MCU && X_MODE > agu_pkg::MODE_PRE
    |=> X_REJECT && !X_VALID)
    else $error("mcu mode not refused");
  bad_seq_a: assert property (@(posedge CLK) disable iff (RESET)
    X_REQ && X_SEQ == agu_pkg::SEQ_ILLEGAL |=> X_REJECT && !X_VALID)
    else $error("illegal sequencing accepted");
  same_cycle_a: assert property (@(posedge CLK) disable iff (RESET)
    X_REQ && x_ok && Y_REQ && y_ok |=> X_VALID && Y_VALID)
    else $error("generators not independent");
  y_mac_only_a: assert property (@(posedge CLK) disable iff (RESET)
    Y_VALID |-> $past(Y_CLASS) == agu_pkg::CLS_MAC && !Y_EA[0])
    else $error("y served non mac");
  y_class_a: assert property (@(posedge CLK) disable iff (RESET)
    Y_REQ && Y_CLASS != agu_pkg::CLS_MAC |=> Y_REJECT && !Y_VALID)
    else $error("y accepted non mac");
  y_post_a: assert property (@(posedge CLK) disable iff (RESET)
    Y_REQ && y_ok && Y_MODE == agu_pkg::MODE_POST
    |=> Y_WB_EN && Y_WB_VAL == 16'($past(Y_PTR_VAL) + $past(Y_STEP))
        && Y_EA == {$past(Y_PTR_VAL[15:1]), 1'b0})
    else $error("y post modify wrong");
  mac_route_a: assert property (@(posedge CLK) disable iff (RESET)
    Y_VALID |-> Y_WB_SEL == agu_pkg::REG_W10 || Y_WB_SEL == agu_pkg::REG_W11)
    else $error("mac pointer routing");
  x_mac_route_a: assert property (@(posedge CLK) disable iff (RESET)
    X_VALID && $past(X_CLASS) == agu_pkg::CLS_MAC
    |-> X_WB_SEL == agu_pkg::REG_W8 || X_WB_SEL == agu_pkg::REG_W9)
    else $error("x mac pointer routing");
  bitrev_data_a: assert property (@(posedge CLK) disable iff (RESET)
    X_BITREV |-> !$past(X_PROG_SPACE) && X_VALID)
    else $error("bitrev in program space");
  regdir_nomem_a: assert property (@(posedge CLK) disable iff (RESET)
    X_REG_OPERAND |-> !X_MEM_ACCESS && $past(X_MODE) == agu_pkg::MODE_RDIR)
    else $error("register direct accessed memory");

  both_gen_c: cover property (@(posedge CLK) disable iff (RESET) X_VALID && Y_VALID);
  post_c:     cover property (@(posedge CLK) disable iff (RESET) X_WB_EN ##1 Y_WB_EN);
  reject_c:   cover property (@(posedge CLK) disable iff (RESET) X_REJECT || Y_REJECT);
  lit_c:      cover property (@(posedge CLK) disable iff (RESET) X_LIT_VALID && X_REG_OPERAND);
  y_ofs_c:    cover property (@(posedge CLK) disable iff (RESET) Y_VALID && !Y_WB_EN);

endmodule : agu_address_generation_unit
`default_nettype wire

/* tb/agu_ptr_model.sv */
`timescale 1ns/1ps
`default_nettype none
module agu_ptr_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Pointer writeback
  input  wire logic        x_wb_en,
  input  wire logic [3:0]  x_wb_sel,
  input  wire logic [15:0] x_wb_val,
  input  wire logic        y_wb_en,
  input  wire logic [3:0]  y_wb_sel,
  input  wire logic [15:0] y_wb_val,
  // Pointer reads
  input  wire logic [3:0]  x_sel,
  input  wire logic [3:0]  y_sel,
  output logic [15:0]      x_ptr,
  output logic [15:0]      y_ptr
);
  logic [15:0] ptr_reg [16];

  // Pointer file, register n starts at n times 0x1000
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < 16; i++)
        ptr_reg[i] <= {i[3:0], 12'h000};
    end
    else
    begin
      if (x_wb_en)
        ptr_reg[x_wb_sel] <= x_wb_val;
      if (y_wb_en)
        ptr_reg[y_wb_sel] <= y_wb_val;
    end
  end
  assign x_ptr = ptr_reg[x_sel];
  assign y_ptr = ptr_reg[y_sel];
endmodule : agu_ptr_model
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        CLK = 1'b0;
  logic        RESET = 1'b1;
  logic        X_REQ, X_PROG_SPACE, X_PRODUCT, X_DEST_W0, Y_REQ;
  logic [1:0]  X_CLASS, X_SEQ, X_LIT_KIND, Y_CLASS, Y_SEQ, X_DEST;
  logic [2:0]  X_MODE, Y_MODE;
  logic [12:0] X_FREG_ADDR;
  logic [9:0]  X_LIT;
  logic [3:0]  X_PTR_SEL, Y_PTR_SEL, X_WB_SEL, Y_WB_SEL;
  logic [15:0] X_FULL_ADDR, X_PTR_VAL, X_OFS_VAL, X_STEP, Y_PTR_VAL, Y_OFS_VAL, Y_STEP;
  logic        X_VALID, X_MEM_ACCESS, X_REG_OPERAND, X_WB_EN, X_BITREV, X_LIT_VALID;
  logic        X_REJECT, Y_VALID, Y_WB_EN, Y_REJECT;
  logic [15:0] X_EA, X_WB_VAL, X_LIT_OUT, Y_EA, Y_WB_VAL;
  int          n_errors = 0;
  int          checks = 0;

  always #12.5 CLK = ~CLK;

  agu_address_generation_unit agu_address_generation_unit_i (
    .CLK, .RESET, .X_REQ, .X_CLASS, .X_MODE, .X_SEQ, .X_PROG_SPACE, .X_PRODUCT, .X_DEST_W0,
    .X_FREG_ADDR, .X_FULL_ADDR, .X_PTR_SEL, .X_PTR_VAL, .X_OFS_VAL, .X_STEP, .X_LIT_KIND,
    .X_LIT, .Y_REQ, .Y_CLASS, .Y_MODE, .Y_SEQ, .Y_PTR_SEL, .Y_PTR_VAL, .Y_OFS_VAL, .Y_STEP,
    .X_VALID, .X_EA, .X_MEM_ACCESS, .X_REG_OPERAND, .X_WB_EN, .X_WB_SEL, .X_WB_VAL, .X_DEST,
    .X_BITREV, .X_LIT_VALID, .X_LIT_OUT, .X_REJECT, .Y_VALID, .Y_EA, .Y_WB_EN, .Y_WB_SEL,
    .Y_WB_VAL, .Y_REJECT);

  agu_ptr_model agu_ptr_model_i (
    .clk(CLK), .rst(RESET), .x_wb_en(X_WB_EN), .x_wb_sel(X_WB_SEL), .x_wb_val(X_WB_VAL),
    .y_wb_en(Y_WB_EN), .y_wb_sel(Y_WB_SEL), .y_wb_val(Y_WB_VAL), .x_sel(X_PTR_SEL),
    .y_sel(Y_PTR_SEL), .x_ptr(X_PTR_VAL), .y_ptr(Y_PTR_VAL));

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Request held from one falling edge to the next, result then settled
  task automatic go(input logic xq, input logic yq);
    X_REQ = xq;
    Y_REQ = yq;
    @(negedge CLK);
  endtask : go

  task automatic s_freg;
    {X_CLASS, X_MODE, X_FREG_ADDR, X_PTR_SEL} = {agu_pkg::CLS_FREG, 3'h0, 13'h1fff, 4'h3};
    go(1'b1, 1'b0);
    chk("freg ea", 16'h1fff, X_EA);
    chk("freg dest", 16'h0000, {14'h0, X_DEST});
    X_DEST_W0 = 1'b1;
    go(1'b1, 1'b0);
    chk("freg dest w0", 16'h0001, {14'h0, X_DEST});
    X_PRODUCT = 1'b1;
    go(1'b1, 1'b0);
    chk("product dest", 16'h0002, {14'h0, X_DEST});
    {X_PRODUCT, X_DEST_W0, X_CLASS, X_FULL_ADDR} = {2'b00, agu_pkg::CLS_XFER, 16'hc002};
    go(1'b1, 1'b0);
    chk("xfer full ea", 16'hc002, X_EA);
  endtask : s_freg

  task automatic s_modes;
    logic [15:0] ea [7];
    ea = '{16'h0, 16'h0, 16'h2000, 16'h2000, 16'h1ffc, 16'h202c, 16'h23fb};
    {X_PTR_SEL, X_OFS_VAL, X_STEP, X_LIT} = {4'h2, 16'h0030, 16'hfffe, 10'h3ff};
    for (int m = 1; m < 7; m++)
    begin
      X_MODE = m[2:0];
      go(1'b1, 1'b0);
      chk("mode valid", 16'h0001, {15'h0, X_VALID});
      chk("mode ea", ea[m], X_EA);
      chk("mode wb", {15'h0, m == 3 || m == 4}, {15'h0, X_WB_EN});
      chk("mode mem", {15'h0, m != 1}, {15'h0, X_MEM_ACCESS});
      go(1'b0, 1'b0);
    end
  endtask : s_modes

  task automatic s_lit;
    {X_CLASS, X_MODE, X_LIT_KIND} = {agu_pkg::CLS_MCU, agu_pkg::MODE_RDIR, agu_pkg::LIT_5};
    go(1'b1, 1'b0);
    chk("lit5", 16'h001f, X_LIT_OUT);
    chk("lit5 valid", 16'h0001, {15'h0, X_LIT_VALID});
    chk("mcu dest", 16'h0003, {14'h0, X_DEST});
    X_LIT_KIND = agu_pkg::LIT_10;
    go(1'b1, 1'b0);
    chk("lit10", 16'h03ff, X_LIT_OUT);
    chk("reg operand", 16'h0001, {15'h0, X_REG_OPERAND});
  endtask : s_lit

  task automatic s_reject;
    logic [7:0] bad [5];
    bad = '{{agu_pkg::CLS_MCU, agu_pkg::MODE_REGOFS, 3'h0}, {agu_pkg::CLS_FREG, 6'h08},
            {agu_pkg::CLS_XFER, 6'h0e}, {agu_pkg::CLS_XFER, 6'h0d}, {agu_pkg::CLS_MAC, 6'h08}};
    {X_PTR_SEL, X_LIT_KIND} = {4'h2, agu_pkg::LIT_NONE};
    for (int i = 0; i < 5; i++)
    begin
      {X_CLASS, X_MODE, X_SEQ, X_PROG_SPACE} = bad[i];
      go(1'b1, 1'b0);
      chk("refused", 16'h0001, {15'h0, X_REJECT});
    end
    {X_CLASS, X_SEQ, X_PROG_SPACE} = {agu_pkg::CLS_XFER, agu_pkg::SEQ_BITREV, 1'b0};
    go(1'b1, 1'b0);
    chk("bitrev flag", 16'h0003, {14'h0, X_BITREV, X_VALID});
    {X_SEQ, X_PROG_SPACE} = {agu_pkg::SEQ_MODULO, 1'b1};
    go(1'b1, 1'b0);
    chk("modulo prog", 16'h0001, {14'h0, X_BITREV, X_VALID});
    {X_SEQ, X_PROG_SPACE} = {agu_pkg::SEQ_LINEAR, 1'b0};
  endtask : s_reject

  task automatic s_mac;
    {X_CLASS, X_MODE, X_PTR_SEL} = {agu_pkg::CLS_MAC, agu_pkg::MODE_RIND, agu_pkg::REG_W8};
    {Y_CLASS, Y_MODE, Y_PTR_SEL} = {agu_pkg::CLS_MAC, agu_pkg::MODE_POST, agu_pkg::REG_W10};
    Y_STEP = 16'h0004;
    go(1'b1, 1'b1);
    chk("x mac ea", 16'h8000, X_EA);
    chk("y mac ea", 16'ha000, Y_EA);
    chk("y wb", 16'ha004, Y_WB_VAL);
    chk("y ok", 16'h0003, {14'h0, Y_WB_EN, Y_VALID});
    {Y_CLASS, Y_MODE, Y_PTR_SEL} = {agu_pkg::CLS_MCU, agu_pkg::MODE_RIND, agu_pkg::REG_W11};
    go(1'b0, 1'b1);
    chk("y class", 16'h0001, {15'h0, Y_REJECT});
    {Y_CLASS, Y_PTR_SEL} = {agu_pkg::CLS_MAC, agu_pkg::REG_W8};
    go(1'b0, 1'b1);
    chk("y ptr", 16'h0001, {15'h0, Y_REJECT});
    {Y_MODE, Y_PTR_SEL, Y_OFS_VAL} = {agu_pkg::MODE_REGOFS, agu_pkg::REG_W11, 16'h0003};
    go(1'b0, 1'b1);
    chk("y ofs ea", 16'hb002, Y_EA);
    chk("y ofs ok", 16'h0001, {14'h0, Y_WB_EN, Y_VALID});
    go(1'b0, 1'b0);
  endtask : s_mac

  task automatic s_wrap;
    {X_CLASS, X_MODE, X_PTR_SEL} = {agu_pkg::CLS_XFER, agu_pkg::MODE_POST, 4'hf};
    X_STEP = 16'h1000;
    go(1'b1, 1'b0);
    chk("post ea", 16'hf000, X_EA);
    chk("post wrap", 16'h0000, X_WB_VAL);
    chk("post wb sel", 16'h000f, {12'h0, X_WB_SEL});
    go(1'b0, 1'b0);
    {X_MODE, X_STEP} = {agu_pkg::MODE_PRE, 16'hfffe};
    go(1'b1, 1'b0);
    chk("pre ea", 16'hfffe, X_EA);
    chk("pre wb", 16'hfffe, X_WB_VAL);
    go(1'b0, 1'b0);
  endtask : s_wrap

  task automatic complete_run;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : complete_run

  initial
  begin
    {X_REQ, Y_REQ, X_PROG_SPACE, X_PRODUCT, X_DEST_W0, X_CLASS, X_SEQ, X_LIT_KIND} = '0;
    {Y_CLASS, Y_SEQ, X_MODE, Y_MODE, X_FREG_ADDR, X_LIT, X_PTR_SEL, Y_PTR_SEL} = '0;
    {X_FULL_ADDR, X_OFS_VAL, X_STEP, Y_OFS_VAL, Y_STEP} = '0;
    repeat (5) @(negedge CLK);
    chk("reset wb sel", 16'h000a, {12'h0, Y_WB_SEL});
    chk("reset valid", 16'h0000, {14'h0, X_VALID, Y_VALID});
    RESET = 1'b0;
    s_freg();
    s_modes();
    s_lit();
    s_reject();
    s_mac();
    s_wrap();
    complete_run();
  end

  // Guard against a hung run
  initial
  begin
    repeat (2000) @(posedge CLK);
    n_errors++;
    complete_run();
  end
endmodule : tb
`default_nettype wire
